// [common/adc_ctrl_pkg.sv]
// constants, types and state codes for the serial converter control block
// assumes a 20 MHz system clock and a host-driven shift clock
// Operation
// RL1: unipolar results are straight binary, bipolar results two's-complement.
// RL2: result bits leave on shift-clock falling edges, most significant first.
// RL3: clock-source bit picks shift clock or internal oscillator for conversion.
// RL4: external mode: strobe high two shift periods right after last control bit.
// RL5: external mode: next eight falls give decided bits, then zeros.
// RL6: external mode: strobe and data float while select high; strobe low after.
// RL7: host finishes external conversions within 1ms, else uses internal mode.
// RL8: internal mode: strobe low while converting, about 25us, high when done.
// RL9: internal mode: result held; MSB on second fall after strobe rises.
// RL10: internal mode: select high blocks input, floats data, not strobe.
// RL11: host keeps acquisition interval at least 1us when shifting fast.
// RL12: select fall starts nothing; first high bit is the start bit.
// RL13: conversion begins at the fall after the eighth control bit.
// RL14: start accepted when idle or once running MSB is on the data line.
// RL15: select toggled mid-conversion: next high bit restarts a new conversion.
// RL16: overlapped conversions reach one per ten shift clocks.
// RL17: after reset: internal mode, strobe high, zeros on data line.
// RL18: power-keep clear: finish conversion, then power down; port stays usable.
// RL19: start bit wakes; power-keep decides whether to stay up afterwards.
// RL20: hard power-down low aborts conversion at once, overriding power-keep.
// RL21: hard power-down pin: high enabled, floating enabled plus reference, low off.
// RL22: result spans 256 codes, transitions at integer LSB points.
// RL23: with select low each rising shift edge captures one input bit.
// RL24: any number of leading zeros before the start bit are ignored.
// RL25: control byte: start, channel select, polarity, input config, keep, clock.
// RL26: clock-source bit 1 is external mode, 0 internal mode.
// RL27: internal conversion is a fixed count of system clock cycles.
package adc_ctrl_pkg;
	localparam int RESULT_CODES = 256;
	localparam int RESULT_BITS = $clog2(RESULT_CODES);
	localparam logic [2:0] RX_LAST_CNT = 3'h6;
	localparam logic [2:0] BIT_MSB_IDX = 3'h7;
	localparam logic [2:0] BIT_NEXT_IDX = 3'h6;
	localparam logic [7:0] SAR_MSB_TRIAL = 8'h80;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic STROBE_INT_RESET = 1'b1;
	localparam logic MODE_EXT_RESET = 1'b0;
	localparam logic POWERED_RESET = 1'b1;
	localparam int CLK_PERIOD_NS = 50;
	localparam int INT_CONV_TIME_NS = 25000;
	localparam int INT_CONV_CYCLES = (INT_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] INT_BIT_CYCLES = 7'(INT_CONV_CYCLES / RESULT_BITS);

	typedef struct packed {
		logic start;
		logic channel_select_hi;
		logic channel_select_mid;
		logic channel_select_lo;
		logic polarity_mode_bit;
		logic input_config_bit;
		logic power_keep_bit;
		logic clock_source_bit;
	} ctrl_byte_t;

	localparam ctrl_byte_t CTRL_RESET = 8'h00;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_STROBE = 2'b01,
		PH_BITS = 2'b10
	} ext_phase_t;

	typedef enum logic [0:0] {
		INT_IDLE = 1'b0,
		INT_CONV = 1'b1
	} int_state_t;
endpackage

// [hdl/adc_ctrl.sv]
// serial port framing, external and internal conversion sequencing, power control
// assumes CS_N_I and DIN_I meet setup to SCLK_I and COMP_I settles combinationally
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl
	import adc_ctrl_pkg::*;
(
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic DIN_I,
	output logic DOUT_O,
	output logic DOUT_OE_N_O,
	output logic END_OF_CONVERSION_STROBE_O,
	output logic END_OF_CONVERSION_STROBE_OE_N_O,
	input wire logic HARD_POWERDOWN_N_I,
	input wire logic HARD_POWERDOWN_FLOAT_I,
	input wire logic COMP_I,
	output logic [7:0] TRIAL_CODE_O,
	output logic [2:0] CHANNEL_SELECT_O,
	output logic INPUT_CONFIG_O,
	output logic POLARITY_UNIPOLAR_O,
	output logic POWERED_O,
	output logic REF_ENABLE_O
);
	// shift-clock domain
	logic srst_s1_reg;
	logic srst_s2_reg;
	logic rx_active_reg;
	logic [2:0] rx_cnt_reg;
	logic cs_toggled_reg;
	logic [5:0] rx_shift_reg;
	ctrl_byte_t ctrl_reg;
	logic launch_tgl_reg;
	logic launch_seen_reg;
	logic mode_ext_reg;
	logic conv_start_tgl_reg;
	logic ext_done_tgl_reg;
	logic busy_reg;
	ext_phase_t phase_reg;
	logic stb_cnt_reg;
	logic [2:0] ext_idx_reg;
	logic [7:0] ext_sar_reg;
	logic ext_strobe_reg;
	logic dout_reg;
	logic [6:0] out_shift_reg;
	logic hpd_sc_s1_reg;
	logic hpd_sc_s2_reg;
	logic idone_s1_reg;
	logic idone_s2_reg;
	logic idone_s3_reg;
	logic int_result_arrived;
	// system clock domain
	logic start_s1_reg;
	logic start_s2_reg;
	logic start_s3_reg;
	logic edone_s1_reg;
	logic edone_s2_reg;
	logic edone_s3_reg;
	logic hpd_s1_reg;
	logic hpd_s2_reg;
	logic float_s1_reg;
	logic float_s2_reg;
	logic start_edge;
	logic ext_done_edge;
	int_state_t int_state_reg;
	logic [6:0] tick_reg;
	logic [2:0] int_idx_reg;
	logic [7:0] int_sar_reg;
	logic [7:0] int_result_reg;
	logic int_strobe_reg;
	logic int_done_tgl_reg;
	logic int_finish;
	logic powered_reg;

	// reset and done crossings; reset needs shift edges, done lands msb at fall two
	always_ff @(posedge SCLK_I)
	begin
		srst_s1_reg <= SRST_I;
		srst_s2_reg <= srst_s1_reg;
		idone_s1_reg <= int_done_tgl_reg;
		idone_s2_reg <= idone_s1_reg;
	end

	// framing; select high clears it at once, so toggles need no shift edge
	always_ff @(posedge SCLK_I or posedge CS_N_I)
	begin
		if (CS_N_I)
		begin
			rx_active_reg <= 1'b0; // RL10
			rx_cnt_reg <= 3'h0;
			cs_toggled_reg <= 1'b1; // RL15
		end
		else if (srst_s2_reg)
		begin
			rx_active_reg <= 1'b0;
			rx_cnt_reg <= 3'h0;
			cs_toggled_reg <= 1'b0;
		end
		else if (!rx_active_reg)
		begin
			// zeros fall through here; a high bit needs an idle or released converter
			if (DIN_I && (!busy_reg || cs_toggled_reg)) // RL12 RL14 RL24
			begin
				rx_active_reg <= 1'b1;
				rx_cnt_reg <= 3'h0;
				cs_toggled_reg <= 1'b0;
			end
		end
		else if (rx_cnt_reg == RX_LAST_CNT)
		begin
			rx_active_reg <= 1'b0;
			rx_cnt_reg <= 3'h0;
		end
		else
		begin
			rx_cnt_reg <= rx_cnt_reg + 3'h1; // RL23
		end
	end

	// control byte capture; bit order start first
	always_ff @(posedge SCLK_I)
	begin
		if (srst_s2_reg)
		begin
			rx_shift_reg <= 6'h00;
			ctrl_reg <= CTRL_RESET;
			launch_tgl_reg <= 1'b0;
		end
		else if (!CS_N_I && rx_active_reg)
		begin
			rx_shift_reg <= {rx_shift_reg[4:0], DIN_I}; // RL23
			if (rx_cnt_reg == RX_LAST_CNT)
			begin
				ctrl_reg <= {1'b1, rx_shift_reg, DIN_I}; // RL25
				launch_tgl_reg <= ~launch_tgl_reg;
			end
		end
	end

	// pin synchroniser and done edge reference on the falling edge
	always_ff @(negedge SCLK_I)
	begin
		hpd_sc_s1_reg <= HARD_POWERDOWN_N_I;
		hpd_sc_s2_reg <= hpd_sc_s1_reg;
		idone_s3_reg <= idone_s2_reg;
	end

	assign int_result_arrived = idone_s2_reg ^ idone_s3_reg; // RL9

	// conversion sequencing and output shifting, all on falling edges
	always_ff @(negedge SCLK_I)
	begin
		if (srst_s2_reg)
		begin
			launch_seen_reg <= 1'b0;
			mode_ext_reg <= MODE_EXT_RESET; // RL17
			conv_start_tgl_reg <= 1'b0;
			ext_done_tgl_reg <= 1'b0;
			busy_reg <= 1'b0;
			phase_reg <= PH_IDLE;
			stb_cnt_reg <= 1'b0;
			ext_idx_reg <= BIT_MSB_IDX;
			ext_sar_reg <= RESULT_RESET;
			ext_strobe_reg <= 1'b0;
			dout_reg <= 1'b0; // RL17
			out_shift_reg <= 7'h00;
		end
		else if (launch_tgl_reg != launch_seen_reg)
		begin
			// new byte complete: start here, dropping any earlier conversion except an internal one when this byte selects external mode
			launch_seen_reg <= launch_tgl_reg; // RL13 RL15
			mode_ext_reg <= ctrl_reg.clock_source_bit; // RL3 RL26
			conv_start_tgl_reg <= ~conv_start_tgl_reg; // RL19
			busy_reg <= 1'b1;
			dout_reg <= 1'b0;
			out_shift_reg <= 7'h00;
			if (ctrl_reg.clock_source_bit)
			begin
				phase_reg <= PH_STROBE;
				stb_cnt_reg <= 1'b0;
				ext_sar_reg <= SAR_MSB_TRIAL;
				ext_strobe_reg <= 1'b1; // RL4
			end
			else
			begin
				phase_reg <= PH_IDLE;
				ext_strobe_reg <= 1'b0;
			end
		end
		else if (!hpd_sc_s2_reg)
		begin
			phase_reg <= PH_IDLE; // RL20
			ext_strobe_reg <= 1'b0;
			busy_reg <= 1'b0;
			dout_reg <= 1'b0;
		end
		else
		begin
			case (phase_reg)
				PH_STROBE:
				begin
					if (stb_cnt_reg)
					begin
						// second period over: MSB decision, inverted for bipolar
						ext_strobe_reg <= 1'b0; // RL4
						dout_reg <= COMP_I ^ ~ctrl_reg.polarity_mode_bit; // RL1 RL2 RL5
						ext_sar_reg <= {COMP_I, 1'b1, 6'h00};
						ext_idx_reg <= BIT_NEXT_IDX;
						busy_reg <= 1'b0; // RL14 RL16
						phase_reg <= PH_BITS;
					end
					else
					begin
						stb_cnt_reg <= 1'b1;
					end
				end
				PH_BITS:
				begin
					dout_reg <= COMP_I; // RL5
					ext_sar_reg[ext_idx_reg] <= COMP_I; // RL22
					if (ext_idx_reg == 3'h0)
					begin
						phase_reg <= PH_IDLE;
						ext_done_tgl_reg <= ~ext_done_tgl_reg; // RL18
					end
					else
					begin
						ext_sar_reg[ext_idx_reg - 3'h1] <= 1'b1;
						ext_idx_reg <= ext_idx_reg - 3'h1;
					end
				end
				PH_IDLE:
				begin
					if (int_result_arrived && !mode_ext_reg)
					begin
						dout_reg <= int_result_reg[7]; // RL9
						out_shift_reg <= int_result_reg[6:0];
						busy_reg <= 1'b0;
					end
					else
					begin
						// past the last bit only zeros remain
						dout_reg <= out_shift_reg[6]; // RL2 RL5
						out_shift_reg <= {out_shift_reg[5:0], 1'b0};
					end
				end
				default:
				begin
					phase_reg <= PH_IDLE;
				end
			endcase
		end
	end

	// system-clock synchronisers
	always_ff @(posedge CLK_I)
	begin
		start_s1_reg <= conv_start_tgl_reg;
		start_s2_reg <= start_s1_reg;
		start_s3_reg <= start_s2_reg;
		edone_s1_reg <= ext_done_tgl_reg;
		edone_s2_reg <= edone_s1_reg;
		edone_s3_reg <= edone_s2_reg;
		hpd_s1_reg <= HARD_POWERDOWN_N_I;
		hpd_s2_reg <= hpd_s1_reg;
		float_s1_reg <= HARD_POWERDOWN_FLOAT_I;
		float_s2_reg <= float_s1_reg;
	end

	assign start_edge = start_s2_reg ^ start_s3_reg;
	assign ext_done_edge = edone_s2_reg ^ edone_s3_reg;
	assign int_finish = (int_state_reg == INT_CONV) && (tick_reg == INT_BIT_CYCLES - 7'h1)
		&& (int_idx_reg == 3'h0);

	// internal-oscillator conversion; mode and control bits are stable by now
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			int_state_reg <= INT_IDLE;
			tick_reg <= 7'h00;
			int_idx_reg <= BIT_MSB_IDX;
			int_sar_reg <= RESULT_RESET;
			int_result_reg <= RESULT_RESET;
			int_strobe_reg <= STROBE_INT_RESET; // RL17
			int_done_tgl_reg <= 1'b0;
		end
		else if (!hpd_s2_reg)
		begin
			int_state_reg <= INT_IDLE; // RL20
			int_strobe_reg <= 1'b1;
		end
		else if (start_edge && !mode_ext_reg)
		begin
			int_state_reg <= INT_CONV; // RL15
			tick_reg <= 7'h00;
			int_idx_reg <= BIT_MSB_IDX;
			int_sar_reg <= SAR_MSB_TRIAL;
			int_strobe_reg <= 1'b0; // RL8
		end
		else
		begin
			case (int_state_reg)
				INT_CONV:
				begin
					if (tick_reg == INT_BIT_CYCLES - 7'h1) // RL27
					begin
						tick_reg <= 7'h00;
						int_sar_reg[int_idx_reg] <= COMP_I; // RL22
						if (int_idx_reg == 3'h0)
						begin
							int_result_reg <= {int_sar_reg[7] ^ ~ctrl_reg.polarity_mode_bit,
								int_sar_reg[6:1], COMP_I}; // RL1
							int_strobe_reg <= 1'b1; // RL8
							int_done_tgl_reg <= ~int_done_tgl_reg; // RL9
							int_state_reg <= INT_IDLE;
						end
						else
						begin
							int_sar_reg[int_idx_reg - 3'h1] <= 1'b1;
							int_idx_reg <= int_idx_reg - 3'h1;
						end
					end
					else
					begin
						tick_reg <= tick_reg + 7'h1;
					end
				end
				INT_IDLE:
				begin
					tick_reg <= 7'h00;
				end
				default:
				begin
					int_state_reg <= INT_IDLE;
				end
			endcase
		end
	end

	// power state: a wake beats a same-cycle power-down from the previous conversion
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			powered_reg <= POWERED_RESET;
		end
		else if (!hpd_s2_reg)
		begin
			powered_reg <= 1'b0; // RL20
		end
		else if (start_edge)
		begin
			powered_reg <= 1'b1; // RL19
		end
		else if ((int_finish || ext_done_edge) && !ctrl_reg.power_keep_bit)
		begin
			powered_reg <= 1'b0; // RL18
		end
	end

	// strobe floats with select only in external mode
	assign END_OF_CONVERSION_STROBE_O = mode_ext_reg ? ext_strobe_reg : int_strobe_reg;
	assign END_OF_CONVERSION_STROBE_OE_N_O = mode_ext_reg & CS_N_I; // RL6 RL10
	assign DOUT_O = dout_reg;
	assign DOUT_OE_N_O = CS_N_I; // RL6 RL10
	assign TRIAL_CODE_O = mode_ext_reg ? ext_sar_reg : int_sar_reg;
	assign CHANNEL_SELECT_O = {ctrl_reg.channel_select_hi, ctrl_reg.channel_select_mid,
		ctrl_reg.channel_select_lo};
	assign INPUT_CONFIG_O = ctrl_reg.input_config_bit;
	assign POLARITY_UNIPOLAR_O = ctrl_reg.polarity_mode_bit;
	assign POWERED_O = powered_reg;
	assign REF_ENABLE_O = hpd_s2_reg & float_s2_reg; // RL21
endmodule
`default_nettype wire

// [sim/adc_ctrl_sva.sv]
// port assertions for the converter control block
// bound from the bench top onto adc_ctrl
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_sva (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic DOUT_O,
	input wire logic DOUT_OE_N_O,
	input wire logic END_OF_CONVERSION_STROBE_O,
	input wire logic END_OF_CONVERSION_STROBE_OE_N_O,
	input wire logic HARD_POWERDOWN_N_I,
	input wire logic HARD_POWERDOWN_FLOAT_I,
	input wire logic COMP_I,
	input wire logic POLARITY_UNIPOLAR_O,
	input wire logic POWERED_O,
	input wire logic REF_ENABLE_O
);
	wire logic s = END_OF_CONVERSION_STROBE_O;
	sequence hpd_low;
		!HARD_POWERDOWN_N_I && !HARD_POWERDOWN_FLOAT_I;
	endsequence
	// strobe seen at falls: high, high, low marks the msb fall
	sequence ext_pulse;
		s [*2] ##1 !s;
	endsequence
	AST_DOUT_FLOAT: assert property (@(posedge CLK_I) disable iff (SRST_I)
		DOUT_OE_N_O == CS_N_I) else $error("data enable not following select");
	AST_STRB_FLOAT: assert property (@(posedge CLK_I) disable iff (SRST_I)
		END_OF_CONVERSION_STROBE_OE_N_O |-> CS_N_I) else $error("strobe floats with select low");
	AST_RST_PWR: assert property (@(posedge CLK_I) disable iff (SRST_I)
		$fell(SRST_I) && HARD_POWERDOWN_N_I |-> POWERED_O) else $error("unpowered after reset");
	AST_HPD_PWR: assert property (@(posedge CLK_I) disable iff (SRST_I)
		hpd_low [*5] |-> !POWERED_O) else $error("powered in hard power-down");
	AST_HPD_STRB: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(!HARD_POWERDOWN_N_I && !HARD_POWERDOWN_FLOAT_I && CS_N_I
		&& !END_OF_CONVERSION_STROBE_OE_N_O) [*6] |-> s)
		else $error("internal strobe low in power-down");
	AST_REF_OFF: assert property (@(posedge CLK_I) disable iff (SRST_I)
		!HARD_POWERDOWN_FLOAT_I [*5] |-> !REF_ENABLE_O) else $error("reference on, pin driven");
	AST_REF_ON: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(HARD_POWERDOWN_FLOAT_I && HARD_POWERDOWN_N_I) [*5] |-> REF_ENABLE_O)
		else $error("reference off, pin floating");
	AST_EXT_MSB: assert property (@(negedge SCLK_I) disable iff (SRST_I)
		ext_pulse |-> DOUT_O == ($past(COMP_I) ^ !POLARITY_UNIPOLAR_O))
		else $error("msb not the first decision");
	AST_EXT_TAIL: assert property (@(negedge SCLK_I) disable iff (SRST_I)
		ext_pulse |-> ##8 !DOUT_O) else $error("no zero after eight bits");
endmodule
`default_nettype wire

// [sim/adc_ctrl_tb_top.sv]
// bench top: host partner, comparator model, frame scoreboard
// reset held until the link clock has pulsed through it
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_tb_top;
	import adc_ctrl_pkg::*;
	typedef struct packed {
		logic [23:0] d;
		logic [23:0] s;
		logic [23:0] m;
	} note_t;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hpd_n = 1'b1;
	logic hpd_fl = 1'b0;
	logic [7:0] ana = 8'h00;
	logic sclk, cs_n, din, dout, doe_n, strb, soe_n, tgl, pwr, ref_en, uni, cfg;
	logic [7:0] trial, c, res;
	logic [2:0] chan;
	logic [23:0] rx_d, rx_s;
	wire logic dpin = doe_n ? 1'bz : dout;
	wire logic spin = soe_n ? 1'bz : strb;
	wire logic comp = ana >= trial;
	note_t notes[$];
	int mismatches = 0;
	int tests_run = 0;
	int z, cnt;
	always #25 clk = ~clk;
	adc_ctrl i_dut (.CLK_I(clk), .SRST_I(srst), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
		.DOUT_O(dout), .DOUT_OE_N_O(doe_n), .END_OF_CONVERSION_STROBE_O(strb),
		.END_OF_CONVERSION_STROBE_OE_N_O(soe_n), .HARD_POWERDOWN_N_I(hpd_n),
		.HARD_POWERDOWN_FLOAT_I(hpd_fl), .COMP_I(comp), .TRIAL_CODE_O(trial),
		.CHANNEL_SELECT_O(chan), .INPUT_CONFIG_O(cfg), .POLARITY_UNIPOLAR_O(uni),
		.POWERED_O(pwr), .REF_ENABLE_O(ref_en));
	host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dpin),
		.strb_i(spin), .rx_d_o(rx_d), .rx_s_o(rx_s), .tgl_o(tgl));
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// sampled on the falling clock edge to stay clear of updates
	task automatic wait_strb(input logic v, input int lim);
		cnt = 0;
		while (strb !== v)
		begin
			@(negedge clk);
			cnt++;
			if (cnt > lim)
			begin
				mismatches++;
				wrap_up();
			end
		end
	endtask
	always @(tgl)
	begin
		note_t n;
		if (notes.size() != 0)
		begin
			n = notes.pop_front();
			chk("dout", n.d, rx_d);
			chk("strobe", n.s, rx_s & n.m);
		end
	end
	initial
	begin
		void'($urandom(32'h9e16));
		i_host.pulses(4);
		@(posedge clk);
		srst <= 1'b0;
		i_host.pulses(4);
		@(negedge clk);
		chk("reset", 24'h3, {21'h0, dout, strb, pwr});
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			res = 8'($urandom);
			ana <= res;
			c = {1'b1, 3'($urandom), 2'b11, k[0], 1'b0};
			notes.push_back('{24'h0, 24'hfe0000, 24'hfe0000});
			i_host.frame({c, 16'h0}, 8);
			wait_strb(1'b0, 20);
			if (k == 1)
			begin
				repeat (100) @(posedge clk);
				hpd_n <= 1'b0;
				wait_strb(1'b1, 8);
				repeat (4) @(negedge clk);
				chk("abort_pwr", 24'h0, 24'(pwr));
			end
			else
			begin
				wait_strb(1'b1, 600);
				chk("int_time", 24'h1, 24'(cnt > 8 * INT_BIT_CYCLES - 3
					&& cnt < 8 * INT_BIT_CYCLES + 3));
				chk("strb_oe", 24'h0, 24'(soe_n));
				repeat (10) @(negedge clk);
				chk("int_pwr", 24'h0, 24'(pwr));
				notes.push_back('{24'(res) << 15, 24'hffffff, 24'hffffff});
				i_host.frame(24'h0, 24);
			end
		end
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			hpd_n <= (k != 0);
			hpd_fl <= (k == 2);
			repeat (6) @(negedge clk);
			chk("ref", 24'(k == 2), 24'(ref_en));
		end
		// uni and keep walk all four pairs; leading zeros vary
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			res = 8'($urandom);
			ana <= res;
			z = $urandom_range(3);
			c = {1'b1, 3'($urandom), i[0], 1'($urandom), i[1], 1'b1};
			notes.push_back('{{16'h0, res ^ {~c[3], 7'h0}} << (7 - z), 24'h3 << (15 - z),
				(24'h1 << (17 - z)) - 24'h1});
			i_host.frame({c, 16'h0} >> z, 24);
			repeat (10) @(negedge clk);
			chk("powered", 24'(c[1]), 24'(pwr));
			chk("strb_float", 24'h1, 24'(soe_n));
			chk("config", {19'h0, c[6:2]}, {19'h0, chan, uni, cfg});
		end
		wrap_up();
	end
endmodule
bind adc_ctrl adc_ctrl_sva i_sva (.CLK_I, .SRST_I, .SCLK_I, .CS_N_I, .DOUT_O, .DOUT_OE_N_O,
	.END_OF_CONVERSION_STROBE_O, .END_OF_CONVERSION_STROBE_OE_N_O, .HARD_POWERDOWN_N_I,
	.HARD_POWERDOWN_FLOAT_I, .COMP_I, .POLARITY_UNIPOLAR_O, .POWERED_O, .REF_ENABLE_O);
`default_nettype wire

// [sim/host_model.sv]
// host serial master: select, shift clock, data in
// samples data out and strobe 40 ns after each fall
`timescale 1ns/100ps
`default_nettype none
module host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o,
	input wire logic dout_i,
	input wire logic strb_i,
	output logic [23:0] rx_d_o,
	output logic [23:0] rx_s_o,
	output logic tgl_o
);
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
		tgl_o = 1'b0;
	end
	// select high: only used to clock the reset through
	task automatic pulses(input int n);
		repeat (n)
		begin
			#80 sclk_o = 1'b1;
			#80 sclk_o = 1'b0;
		end
	endtask
	// clock idles low and stands still between frames
	task automatic frame(input logic [23:0] w, input int n);
		#13 cs_n_o = 1'b0;
		rx_d_o = 24'h0;
		rx_s_o = 24'h0;
		for (int i = 0; i < n; i++)
		begin
			din_o = w[23 - i];
			if (n == 8 && i == 7) #1000;
			#40 sclk_o = 1'b1;
			#80 sclk_o = 1'b0;
			#40 rx_d_o[23 - i] = dout_i;
			rx_s_o[23 - i] = strb_i;
		end
		#40 cs_n_o = 1'b1;
		din_o = ~din_o;
		tgl_o = ~tgl_o;
	endtask
endmodule
`default_nettype wire
